// [dv/testbench.sv]
// self-checking bench for the field capture sequencer
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import vcfs_pkg::*;
  logic           clk;
  logic           resetn;
  vcfs_ctl_t      ctl;
  logic           en;
  vcfs_done_t     clr_v;
  vcfs_field_ev_t field_ev;
  logic           capture_active;
  logic           field_one_done;
  logic           field_two_done;
  logic           whole_frame_done;
  logic           capture_complete_irq;
  logic           capture_halted;
  logic           mode_reserved;
  int             bad_count;
  int             tests_run;
  int             cap_cnt = 0;
  int             irq_cnt = 0;
  int             cyc = 0;
  int             flen;

  vcfs_sequencer i_vcfs_sequencer (
    .clk                    (clk),
    .resetn                 (resetn),
    .capture_control_reg    (ctl),
    .capture_channel_enable (en),
    .clear_done             (clr_v),
    .field_ev               (field_ev),
    .capture_active         (capture_active),
    .field_one_done         (field_one_done),
    .field_two_done         (field_two_done),
    .whole_frame_done       (whole_frame_done),
    .capture_complete_irq   (capture_complete_irq),
    .capture_halted         (capture_halted),
    .mode_reserved          (mode_reserved)
  );

  vcfs_src_model i_vcfs_src_model (
    .clk      (clk),
    .field_ev (field_ev)
  );

  // 40 MHz clock
  initial clk = 1'b0;
  always #12.5 clk = ~clk;

  // count gate cycles and irq pulses; a one-cycle pulse is seen at the edge that ends it
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (capture_active === 1'b1) cap_cnt <= cap_cnt + 1;
    if (capture_complete_irq === 1'b1) irq_cnt <= irq_cnt + 1;
    if (cyc == 5000) begin
      bad_count = bad_count + 1;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [3:0] seen, input logic [3:0] exp, input string msg);
    tests_run = tests_run + 1;
    if (seen !== exp) begin
      bad_count = bad_count + 1;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  // software clear pulse, one cycle
  task automatic clr(input logic [2:0] bits);
    @(negedge clk);
    clr_v = bits;
    @(negedge clk);
    clr_v = '0;
  endtask

  // new mode between fields; stale flags cleared so each mode starts clean
  task automatic md(input logic [3:0] code);
    @(negedge clk);
    ctl = code;
    clr(3'h7);
    repeat (2) @(negedge clk);
  endtask

  // one field from the source, then gate, flags and irq count compared
  task automatic f(input logic two, input logic cap, input logic [2:0] fl, input logic irq);
    int c0;
    int i0;
    c0 = cap_cnt;
    i0 = irq_cnt;
    i_vcfs_src_model.send(two, flen);
    @(negedge clk);
    chk({3'h0, cap_cnt != c0}, {3'h0, cap}, "capture gate");
    chk({1'b0, whole_frame_done, field_two_done, field_one_done}, {1'b0, fl}, "done flags");
    chk(4'(irq_cnt - i0), {3'h0, irq}, "irq pulses");
  endtask

  initial begin
    bad_count = 0;
    tests_run = 0;
    flen = 4;
    resetn = 1'b0;
    ctl = ENC_NC_FIELD1;
    en = 1'b1;
    clr_v = '0;
    repeat (2) @(negedge clk);
    resetn = 1'b1;
    @(negedge clk);
    chk({1'b0, whole_frame_done, field_two_done, field_one_done}, 4'h0, "reset flags");
    chk({capture_active, capture_complete_irq, capture_halted, 1'b0}, 4'h0, "reset outputs");
    // field one only, halts until cleared
    f(1'b0, 1'b1, 3'h1, 1'b1);
    f(1'b1, 1'b0, 3'h1, 1'b0);
    f(1'b0, 1'b0, 3'h1, 1'b0);
    chk({3'h0, capture_halted}, 4'h1, "halted");
    clr(3'h1);
    f(1'b0, 1'b1, 3'h1, 1'b1);
    chk({3'h0, capture_halted}, 4'h0, "resumed");
    // field two only
    md(ENC_NC_FIELD2);
    f(1'b1, 1'b1, 3'h2, 1'b1);
    f(1'b0, 1'b0, 3'h2, 1'b0);
    f(1'b1, 1'b0, 3'h2, 1'b0);
    clr(3'h2);
    f(1'b1, 1'b1, 3'h2, 1'b1);
    // both fields, slow source
    md(ENC_NC_BOTH);
    flen = 20;
    f(1'b0, 1'b1, 3'h1, 1'b1);
    f(1'b1, 1'b1, 3'h3, 1'b1);
    f(1'b0, 1'b0, 3'h3, 1'b0);
    clr(3'h1);
    f(1'b0, 1'b1, 3'h3, 1'b1);
    f(1'b1, 1'b0, 3'h3, 1'b0);
    flen = 4;
    // frame: one more frame after the flag, then halt
    md(ENC_NC_FRAME);
    f(1'b0, 1'b1, 3'h0, 1'b0);
    f(1'b1, 1'b1, 3'h4, 1'b1);
    f(1'b0, 1'b1, 3'h4, 1'b0);
    f(1'b1, 1'b1, 3'h4, 1'b1);
    f(1'b0, 1'b0, 3'h4, 1'b0);
    f(1'b1, 1'b0, 3'h4, 1'b0);
    clr(3'h4);
    f(1'b0, 1'b1, 3'h0, 1'b0);
    f(1'b1, 1'b1, 3'h4, 1'b1);
    // progressive frame on field one
    md(ENC_NC_PROG);
    f(1'b0, 1'b1, 3'h4, 1'b1);
    f(1'b1, 1'b0, 3'h4, 1'b0);
    f(1'b0, 1'b1, 3'h4, 1'b1);
    f(1'b0, 1'b0, 3'h4, 1'b0);
    clr(3'h4);
    f(1'b0, 1'b1, 3'h4, 1'b1);
    // single frame
    md(ENC_SINGLE);
    f(1'b0, 1'b1, 3'h0, 1'b0);
    f(1'b1, 1'b1, 3'h4, 1'b1);
    f(1'b0, 1'b0, 3'h4, 1'b0);
    f(1'b1, 1'b0, 3'h4, 1'b0);
    clr(3'h4);
    f(1'b0, 1'b1, 3'h0, 1'b0);
    // continuous modes never halt on their flag
    md(ENC_C_FIELD1);
    f(1'b0, 1'b1, 3'h1, 1'b1);
    f(1'b1, 1'b0, 3'h1, 1'b0);
    f(1'b0, 1'b1, 3'h1, 1'b1);
    md(ENC_C_FIELD2);
    f(1'b1, 1'b1, 3'h2, 1'b1);
    f(1'b0, 1'b0, 3'h2, 1'b0);
    f(1'b1, 1'b1, 3'h2, 1'b1);
    md(ENC_C_FRAME);
    f(1'b0, 1'b1, 3'h0, 1'b0);
    f(1'b1, 1'b1, 3'h4, 1'b1);
    f(1'b0, 1'b1, 3'h4, 1'b0);
    f(1'b1, 1'b1, 3'h4, 1'b1);
    md(ENC_C_PROG);
    f(1'b0, 1'b1, 3'h4, 1'b1);
    f(1'b1, 1'b0, 3'h4, 1'b0);
    f(1'b0, 1'b1, 3'h4, 1'b1);
    // disabled channel captures nothing
    md(ENC_C_FIELD1);
    en = 1'b0;
    f(1'b0, 1'b0, 3'h0, 1'b0);
    en = 1'b1;
    // reserved code refuses everything
    md(4'h0);
    chk({3'h0, mode_reserved}, 4'h1, "reserved mode");
    f(1'b0, 1'b0, 3'h0, 1'b0);
    end_of_test();
  end
endmodule
`default_nettype wire

// [dv/vcfs_src_model.sv]
// behavioural video source that hands fields to the sequencer
`timescale 1ns/1ps
`default_nettype none
module vcfs_src_model
  import vcfs_pkg::*;
(
  // clock
  input  wire logic         clk,
  // field events towards the sequencer
  output var vcfs_field_ev_t field_ev
);
  // idle until the bench asks for a field
  initial field_ev = '0;

  // one field: start pulse, open for len cycles, then a done pulse
  task automatic send(input logic two, input int len);
    @(negedge clk);
    field_ev = '{start: 1'b1, is_two: two, done: 1'b0};
    @(negedge clk);
    // parity is only valid with start, so show the inverse afterwards
    field_ev = '{start: 1'b0, is_two: !two, done: 1'b0};
    repeat (len) @(negedge clk);
    field_ev.done = 1'b1;
    @(negedge clk);
    field_ev.done = 1'b0;
  endtask
endmodule
`default_nettype wire

// [logic/vcfs_done_flag.sv]
// one sticky completion flag, hardware set beats software clear
`timescale 1ns/1ps
`default_nettype none
module vcfs_done_flag
  import vcfs_pkg::*;
(
  // clock and reset
  input  wire logic clk,
  input  wire logic resetn,
  // events
  input  wire logic set,
  input  wire logic clear,
  // flag
  output logic      done
);

  // a completion landing on the clear cycle must not be lost
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      done <= DONE_RESET;
    end else if (set) begin
      done <= 1'b1;
    end else if (clear) begin
      done <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// [logic/vcfs_mode_decode.sv]
// registered decode of the four capture control bits into a mode
`timescale 1ns/1ps
`default_nettype none
module vcfs_mode_decode
  import vcfs_pkg::*;
(
  // clock and reset
  input  wire logic clk,
  input  wire logic resetn,
  // control bits
  input  wire vcfs_ctl_t ctl,
  // decoded mode
  output vcfs_mode_t     mode
);

  // reserved codes fall back to capturing nothing
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mode <= MODE_RESERVED;
    end else begin
      case (ctl)
        ENC_NC_FIELD1: mode <= MODE_NC_FIELD1;
        ENC_NC_FIELD2: mode <= MODE_NC_FIELD2;
        ENC_NC_BOTH:   mode <= MODE_NC_BOTH;
        ENC_NC_FRAME:  mode <= MODE_NC_FRAME;
        ENC_NC_PROG:   mode <= MODE_NC_PROG;
        ENC_SINGLE:    mode <= MODE_SINGLE;
        ENC_C_FIELD1:  mode <= MODE_C_FIELD1;
        ENC_C_FIELD2:  mode <= MODE_C_FIELD2;
        ENC_C_FRAME:   mode <= MODE_C_FRAME;
        ENC_C_PROG:    mode <= MODE_C_PROG;
        default:       mode <= MODE_RESERVED;
      endcase
    end
  end

endmodule
`default_nettype wire

// [logic/vcfs_pkg.sv]
// shared constants, carriers and helpers of the video capture field sequencer
package vcfs_pkg;

  // control encodings {continuous, frame, field two, field one}
  localparam logic [3:0] ENC_NC_FIELD1 = 4'h1;
  localparam logic [3:0] ENC_NC_FIELD2 = 4'h2;
  localparam logic [3:0] ENC_NC_BOTH   = 4'h3;
  localparam logic [3:0] ENC_NC_FRAME  = 4'h4;
  localparam logic [3:0] ENC_NC_PROG   = 4'h5;
  localparam logic [3:0] ENC_SINGLE    = 4'h7;
  localparam logic [3:0] ENC_C_FIELD1  = 4'h9;
  localparam logic [3:0] ENC_C_FIELD2  = 4'ha;
  localparam logic [3:0] ENC_C_FRAME   = 4'hc;
  localparam logic [3:0] ENC_C_PROG    = 4'hd;

  // reset values
  localparam logic DONE_RESET = 1'b0;

  typedef struct packed {
    logic continuous_capture_sel;
    logic frame_sel;
    logic field_two_select;
    logic field_one_select;
  } vcfs_ctl_t;

  typedef struct packed {
    logic whole_frame;
    logic field_two;
    logic field_one;
  } vcfs_done_t;

  // field events from the capture front end, same clock
  typedef struct packed {
    logic start;
    logic is_two;
    logic done;
  } vcfs_field_ev_t;

  typedef enum logic [3:0] {
    MODE_RESERVED,
    MODE_NC_FIELD1,
    MODE_NC_FIELD2,
    MODE_NC_BOTH,
    MODE_NC_FRAME,
    MODE_NC_PROG,
    MODE_SINGLE,
    MODE_C_FIELD1,
    MODE_C_FIELD2,
    MODE_C_FRAME,
    MODE_C_PROG
  } vcfs_mode_t;

  // which field parity a mode captures at all
  function automatic logic vcfs_field_selected(input vcfs_mode_t mode, input logic is_two);
    logic sel;
    sel = 1'b0;
    case (mode)
      MODE_NC_FIELD1, MODE_C_FIELD1, MODE_NC_PROG, MODE_C_PROG: sel = !is_two;
      MODE_NC_FIELD2, MODE_C_FIELD2:                            sel = is_two;
      MODE_NC_BOTH, MODE_NC_FRAME, MODE_SINGLE, MODE_C_FRAME:   sel = 1'b1;
      default:                                                  sel = 1'b0;
    endcase
    return sel;
  endfunction

  // flags raised when a captured field completes
  function automatic vcfs_done_t vcfs_done_for(input vcfs_mode_t mode, input logic is_two);
    vcfs_done_t d;
    d = '0;
    case (mode)
      MODE_NC_FIELD1, MODE_C_FIELD1: d.field_one   = !is_two;
      MODE_NC_FIELD2, MODE_C_FIELD2: d.field_two   = is_two;
      MODE_NC_BOTH: begin
        d.field_one = !is_two;
        d.field_two = is_two;
      end
      MODE_NC_FRAME, MODE_SINGLE, MODE_C_FRAME: d.whole_frame = is_two;
      MODE_NC_PROG, MODE_C_PROG:                d.whole_frame = !is_two;
      default:                                  d = '0;
    endcase
    return d;
  endfunction

endpackage

// [logic/vcfs_sequencer.sv]
// per-channel field and frame capture sequencer
`timescale 1ns/1ps
`default_nettype none
module vcfs_sequencer
  import vcfs_pkg::*;
(
  // clock and reset
  input  wire logic           clk,
  input  wire logic           resetn,
  // software control
  input  wire vcfs_ctl_t      capture_control_reg,
  input  wire logic           capture_channel_enable,
  input  wire vcfs_done_t     clear_done,
  // field events from the front end
  input  wire vcfs_field_ev_t field_ev,
  // capture gate towards the fifo packer
  output logic                capture_active,
  // status
  output logic                field_one_done,
  output logic                field_two_done,
  output logic                whole_frame_done,
  output logic                capture_complete_irq,
  output logic                capture_halted,
  output logic                mode_reserved
);

  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_CAPTURE,
    SEQ_SKIP
  } vcfs_seq_t;

  vcfs_mode_t mode;
  vcfs_seq_t  state;
  logic       cur_two;
  logic       frame_open;
  logic       frame_halted;
  logic       sel;
  logic       gate_ok;
  logic       next_take;
  logic       field_closes;
  vcfs_done_t done_set;
  logic       frame_mode;
  logic       halt_mode;

  // control decode is registered, so mode edits land one cycle later
  vcfs_mode_decode u_decode (
    .clk    (clk),
    .resetn (resetn),
    .ctl    (capture_control_reg),
    .mode   (mode)
  );

  // two-field frame modes pair field two with a captured field one
  assign frame_mode = (mode == MODE_NC_FRAME) || (mode == MODE_SINGLE) || (mode == MODE_C_FRAME);
  // modes that halt only after one more whole frame
  assign halt_mode  = (mode == MODE_NC_FRAME) || (mode == MODE_NC_PROG);

  // capture decision taken afresh at every field start
  always_comb begin
    sel     = vcfs_field_selected(mode, field_ev.is_two);
    gate_ok = 1'b1;
    case (mode)
      MODE_NC_FIELD1: gate_ok = !field_one_done;
      MODE_NC_FIELD2: gate_ok = !field_two_done;
      MODE_NC_BOTH:   gate_ok = field_ev.is_two ? !field_two_done : !field_one_done;
      MODE_NC_FRAME:  gate_ok = field_ev.is_two ? frame_open : (!frame_halted || !whole_frame_done);
      MODE_NC_PROG:   gate_ok = !frame_halted || !whole_frame_done;
      MODE_SINGLE:    gate_ok = field_ev.is_two ? frame_open : !whole_frame_done;
      MODE_C_FRAME:   gate_ok = !field_ev.is_two || frame_open;
      default:        gate_ok = 1'b1;
    endcase
    next_take = capture_channel_enable && sel && gate_ok;
  end

  // a field completes only if it was being captured
  assign field_closes = (state == SEQ_CAPTURE) && field_ev.done;
  assign done_set     = field_closes ? vcfs_done_for(mode, cur_two) : '0;

  // per-field sequencing; a new start overrides an unfinished field
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state <= SEQ_IDLE;
    end else if (field_ev.start) begin
      state <= next_take ? SEQ_CAPTURE : SEQ_SKIP;
    end else if (field_ev.done) begin
      state <= SEQ_IDLE;
    end
  end

  // parity of the field in progress
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cur_two <= 1'b0;
    end else if (field_ev.start) begin
      cur_two <= field_ev.is_two;
    end
  end

  // write gate mirrors the capture state as a flop for the packer
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      capture_active <= 1'b0;
    end else if (field_ev.start) begin
      capture_active <= next_take;
    end else if (field_ev.done) begin
      capture_active <= 1'b0;
    end
  end

  // field one of a frame captured, field two may follow
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      frame_open <= 1'b0;
    end else if (field_ev.start) begin
      frame_open <= 1'b0;
    end else if (field_closes && !cur_two && frame_mode) begin
      frame_open <= 1'b1;
    end
  end

  // halt after a frame completes with its flag still pending
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      frame_halted <= 1'b0;
    end else if (!halt_mode) begin
      frame_halted <= 1'b0;
    end else if (done_set.whole_frame && whole_frame_done) begin
      frame_halted <= 1'b1;
    end else if (field_ev.start && !field_ev.is_two && !whole_frame_done) begin
      frame_halted <= 1'b0;
    end
  end

  // completion flags
  vcfs_done_flag u_flag_one (
    .clk    (clk),
    .resetn (resetn),
    .set    (done_set.field_one),
    .clear  (clear_done.field_one),
    .done   (field_one_done)
  );

  vcfs_done_flag u_flag_two (
    .clk    (clk),
    .resetn (resetn),
    .set    (done_set.field_two),
    .clear  (clear_done.field_two),
    .done   (field_two_done)
  );

  vcfs_done_flag u_flag_frame (
    .clk    (clk),
    .resetn (resetn),
    .set    (done_set.whole_frame),
    .clear  (clear_done.whole_frame),
    .done   (whole_frame_done)
  );

  // one-cycle capture-complete event; masking belongs to the port interrupt logic
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      capture_complete_irq <= 1'b0;
    end else begin
      capture_complete_irq <= |done_set;
    end
  end

  // halted: last selected field was refused by its gate, either a pending flag or no open frame for field two
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      capture_halted <= 1'b0;
    end else if (!capture_channel_enable) begin
      capture_halted <= 1'b0;
    end else if (field_ev.start && sel) begin
      capture_halted <= !gate_ok;
    end
  end

  // reserved code flag; the block then captures nothing
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mode_reserved <= 1'b0;
    end else begin
      mode_reserved <= (mode == MODE_RESERVED);
    end
  end

  // field one mode never writes field two data
  only_field_one_a: assert property (@(posedge clk) disable iff (!resetn)
    (field_ev.start && field_ev.is_two && (mode == MODE_NC_FIELD1)) |=> !capture_active)
    else $error("field two captured in field one mode");

  // a pending field one flag blocks the next field one
  pending_blocks_a: assert property (@(posedge clk) disable iff (!resetn)
    (field_ev.start && !field_ev.is_two && capture_channel_enable && (mode == MODE_NC_FIELD1) && field_one_done)
    |=> !capture_active && capture_halted)
    else $error("field captured while its flag pending");

  // cleared flag lets capture resume at the next field start
  resume_capture_a: assert property (@(posedge clk) disable iff (!resetn)
    (field_ev.start && !field_ev.is_two && capture_channel_enable
     && (mode == MODE_NC_BOTH) && !field_one_done) |=> capture_active)
    else $error("capture did not resume after clear");

  // completed field two sets its flag and the event
  field_two_flag_a: assert property (@(posedge clk) disable iff (!resetn)
    (field_closes && cur_two && (mode == MODE_NC_FIELD2))
    |=> field_two_done && capture_complete_irq ##1 !capture_complete_irq)
    else $error("field two completion not flagged");

  // continuous field one ignores its own flag
  cont_field_one_a: assert property (@(posedge clk) disable iff (!resetn)
    (field_ev.start && !field_ev.is_two && capture_channel_enable && (mode == MODE_C_FIELD1))
    |=> capture_active)
    else $error("continuous field one refused a field");

  // continuous field two ignores its own flag
  cont_field_two_a: assert property (@(posedge clk) disable iff (!resetn)
    (field_ev.start && field_ev.is_two && capture_channel_enable && (mode == MODE_C_FIELD2))
    |=> capture_active)
    else $error("continuous field two refused a field");

  // continuous progressive raises the frame flag, not field one
  cont_prog_flag_a: assert property (@(posedge clk) disable iff (!resetn)
    (field_closes && !cur_two && (mode == MODE_C_PROG))
    |=> whole_frame_done && capture_complete_irq && !$rose(field_one_done))
    else $error("continuous progressive used the wrong flag");

  // single frame stays stopped while the frame flag is set
  single_stop_a: assert property (@(posedge clk) disable iff (!resetn)
    (field_ev.start && !field_ev.is_two && (mode == MODE_SINGLE) && whole_frame_done)
    |=> !capture_active)
    else $error("single frame captured with flag pending");

  // second frame with flag pending halts frame mode
  frame_halt_a: assert property (@(posedge clk) disable iff (!resetn)
    (field_closes && cur_two && (mode == MODE_NC_FRAME) && whole_frame_done)
    |=> frame_halted)
    else $error("frame mode failed to halt");

  // progressive modes ignore field two entirely
  prog_field_two_a: assert property (@(posedge clk) disable iff (!resetn)
    (field_ev.start && field_ev.is_two && ((mode == MODE_NC_PROG) || (mode == MODE_C_PROG)))
    |=> !capture_active)
    else $error("field two captured in progressive mode");

  // disabled channel writes nothing
  disabled_gate_a: assert property (@(posedge clk) disable iff (!resetn)
    (field_ev.start && !capture_channel_enable) |=> !capture_active)
    else $error("capture with channel disabled");

  // every completion event comes from a captured field ending
  irq_cause_a: assert property (@(posedge clk) disable iff (!resetn)
    $rose(capture_complete_irq) |-> $past(field_closes))
    else $error("completion event without a captured field");

  // field one mode raises its own flag and the event
  field_one_flag_a: assert property (@(posedge clk) disable iff (!resetn)
    (field_closes && !cur_two && (mode == MODE_NC_FIELD1)) |=> field_one_done && capture_complete_irq)
    else $error("field one completion not flagged");

  // dual field mode flags field one on its own
  dual_flag_one_a: assert property (@(posedge clk) disable iff (!resetn)
    (field_closes && !cur_two && (mode == MODE_NC_BOTH)) |=> field_one_done && capture_complete_irq)
    else $error("dual mode field one not flagged");

  // dual field mode flags field two on its own
  dual_flag_two_a: assert property (@(posedge clk) disable iff (!resetn)
    (field_closes && cur_two && (mode == MODE_NC_BOTH)) |=> field_two_done && capture_complete_irq)
    else $error("dual mode field two not flagged");

  // two-field frame modes flag the frame after field two
  frame_flag_set_a: assert property (@(posedge clk) disable iff (!resetn)
    (field_closes && cur_two && frame_mode) |=> whole_frame_done && capture_complete_irq)
    else $error("frame completion not flagged");

  // progressive frame mode flags the frame, not field one
  prog_frame_flag_a: assert property (@(posedge clk) disable iff (!resetn)
    (field_closes && !cur_two && (mode == MODE_NC_PROG))
    |=> whole_frame_done && capture_complete_irq && !$rose(field_one_done))
    else $error("progressive frame used the wrong flag");

  // halted frame mode refuses field one while the flag is pending
  frame_halt_gate_a: assert property (@(posedge clk) disable iff (!resetn)
    (field_ev.start && !field_ev.is_two && capture_channel_enable && (mode == MODE_NC_FRAME)
     && frame_halted && whole_frame_done) |=> !capture_active && capture_halted)
    else $error("halted frame mode captured a field");

  // continuous frame mode takes every field one
  cont_frame_run_a: assert property (@(posedge clk) disable iff (!resetn)
    (field_ev.start && !field_ev.is_two && capture_channel_enable && (mode == MODE_C_FRAME))
    |=> capture_active)
    else $error("continuous frame refused a field");

  // the write gate closes when a field ends
  field_end_gate_a: assert property (@(posedge clk) disable iff (!resetn)
    (field_ev.done && !field_ev.start) |=> !capture_active)
    else $error("write gate open after field end");

  // a software clear without a new completion drops the flag
  flag_clear_a: assert property (@(posedge clk) disable iff (!resetn)
    (clear_done.field_one && !done_set.field_one) |=> !field_one_done)
    else $error("field one flag not cleared");

  // continuous field two still raises its flag and event
  cont_two_flag_a: assert property (@(posedge clk) disable iff (!resetn)
    (field_closes && cur_two && (mode == MODE_C_FIELD2)) |=> field_two_done && capture_complete_irq)
    else $error("continuous field two not flagged");

endmodule
`default_nettype wire
